// >>> hw/pmc_consts.vh
// Purpose: constants of the power mode controller
// Assumes: included by pmc_top.v and by the bench
// Notes: byte offsets on a 32-bit APB, one word per register
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// register byte offsets
`define PMC_OFS_CTRL1 8'h00
`define PMC_OFS_CTRL2 8'h04
`define PMC_OFS_TMRA 8'h08
`define PMC_OFS_CCR 8'h0c
`define PMC_OFS_IEN 8'h10
`define PMC_OFS_MODE 8'h14
`define PMC_OFS_ISTAT 8'h18
`define PMC_OFS_IMASK 8'h1c

// system_control_reg_one fields
`define PMC_C1_STANDBY_ENABLE 7
`define PMC_C1_STS_HI 6
`define PMC_C1_STS_LO 4
`define PMC_C1_LOW_SPEED_SELECT 3
`define PMC_C1_DIV_HI 1
`define PMC_C1_DIV_LO 0
`define PMC_C1_MASK 8'hfb

// system_control_reg_two fields
`define PMC_C2_DIRECT_TRANSFER_ENABLE 3
`define PMC_C2_MEDIUM_SPEED_SELECT 2
`define PMC_C2_MASK 8'h0c

// timer_a_mode_reg and condition_code_reg fields
`define PMC_TM_WTS 3
`define PMC_CC_IMASK 7

// interrupt enable bits
`define PMC_IE_EXT_INTERRUPT_ZERO 0
`define PMC_IE_EXT_INTERRUPT_ONE 1
`define PMC_IE_TMRA 2
`define PMC_IE_OTHER 3
`define PMC_IE_DT 4

// sticky event bits
`define PMC_EV_MODE 0
`define PMC_EV_DT 1
`define PMC_EV_WAKE 2

// reset values
`define PMC_RST_BYTE 8'h00
`define PMC_RST_CCR 8'h80
`define PMC_RST_IEN 5'h00
`define PMC_RST_EV 3'h0

// settling and clock divider counts
`define PMC_SETTLE_STATES 18'h02000
`define PMC_STS_TOP_SHIFT 3'h4
`define PMC_CNT_ONE 18'h00001
`define PMC_CNT_ZERO 18'h00000
`define PMC_MS_DIV_BASE 7'h08
`define PMC_SUB_DIV_M1 7'h7f
`define PMC_DIV_ZERO 7'h00
`define PMC_DIV_ONE 7'h01

`endif

// >>> hw/pmc_top.v
// Purpose: power mode sequencer with APB registers
// Assumes: sleep_exec_in is a one-cycle pulse on clk_in
// Notes: one settling state equals one clk_in cycle
//
// Contract
// [R1] medium speed set: standby, watch, sleep wakes enter medium active
// [R2] no wake transition while mask bit set or source disabled
// [R3] medium active sleep, standby on, low speed off, watch off: standby
// [R4] medium active sleep, standby on, watch timer on: watch mode
// [R5] sleep with standby and low speed off: high or medium sleep
// [R6] reset pin low ends any mode and holds cpu in reset
// [R7] medium active cpu clock rate set by two-bit divider field
// [R8] direct transfer switches active modes, then starts its exception
// [R9] direct transfer interrupt disabled: enter sleep or watch instead
// [R10] direct transfer with mask set: sleep or watch, never woken
// [R11] high active to medium active through sleep mode
// [R12] medium active to high active through sleep mode
// [R13] either active mode to subactive through watch mode
// [R14] subactive to active through watch after settling wait
// [R15] settling code gives 8192 to 65536 states, top bit 131072
// [R16] one one-hot mode register, changed only by sleep, wake, reset
`timescale 1ns/1ps
`include "pmc_consts.vh"

module pmc_top #(
  parameter [17:0] settle_base = `PMC_SETTLE_STATES
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // cpu side
  input wire sleep_exec_in,
  input wire reset_pin_n_in,
  input wire ext_interrupt_zero_in,
  input wire ext_interrupt_one_in,
  input wire timer_a_irq_in,
  input wire other_irq_in,
  // mode outputs
  output reg [9:0] mode_out,
  output reg cpu_reset_out,
  output reg cpu_clk_en_out,
  output reg dt_exc_out,
  output reg wake_exc_out,
  output reg irq_out
);

  // ********************************
  // mode states
  // ********************************
  localparam [9:0] ST_RST = 10'h001;
  localparam [9:0] ST_AHS = 10'h002;
  localparam [9:0] ST_AMS = 10'h004;
  localparam [9:0] ST_SUB = 10'h008;
  localparam [9:0] ST_SHS = 10'h010;
  localparam [9:0] ST_SMS = 10'h020;
  localparam [9:0] ST_STB = 10'h040;
  localparam [9:0] ST_WAT = 10'h080;
  localparam [9:0] ST_SSL = 10'h100;
  localparam [9:0] ST_SET = 10'h200;

  // ********************************
  // functions
  // ********************************
  function [17:0] settle_cycles;
    input [2:0] code;
    begin
      if (code[2]) begin
        settle_cycles = settle_base << `PMC_STS_TOP_SHIFT; // R15
      end else begin
        settle_cycles = settle_base << code[1:0]; // R15
      end
    end
  endfunction

  function [7:0] apb_byte;
    input [31:0] d;
    begin
      apb_byte = d[7:0];
    end
  endfunction

  // ********************************
  // registers and state
  // ********************************
  reg [7:0] ctrl1;
  reg [7:0] ctrl2;
  reg [7:0] tmra;
  reg [7:0] condition_code_reg;
  reg [4:0] ien;
  reg [2:0] istat;
  reg [2:0] imask;
  reg [9:0] mode;
  reg [9:0] tgt;
  reg pend;
  reg lock;
  reg [17:0] cnt;
  reg [6:0] dcnt;
  reg [1:0] rpin_sync;
  reg [3:0] irq_s1;
  reg [3:0] irq_s2;

  reg [9:0] next_mode;
  reg [9:0] next_tgt;
  reg next_pend;
  reg next_lock;
  reg [17:0] next_cnt;
  reg ev_dt;
  reg ev_wake;
  reg [31:0] next_rdata;
  reg next_err;

  wire standby_enable = ctrl1[`PMC_C1_STANDBY_ENABLE];
  wire low_speed_select = ctrl1[`PMC_C1_LOW_SPEED_SELECT];
  wire [2:0] sts = ctrl1[`PMC_C1_STS_HI:`PMC_C1_STS_LO];
  wire [1:0] mdiv = ctrl1[`PMC_C1_DIV_HI:`PMC_C1_DIV_LO];
  wire medium_speed_select = ctrl2[`PMC_C2_MEDIUM_SPEED_SELECT];
  wire direct_transfer_enable = ctrl2[`PMC_C2_DIRECT_TRANSFER_ENABLE];
  wire watch_timer_select = tmra[`PMC_TM_WTS];
  wire imask_bit = condition_code_reg[`PMC_CC_IMASK];
  wire rpin = rpin_sync[1];
  wire [9:0] act_tgt = medium_speed_select ? ST_AMS : ST_AHS;
  // a locked-out mode ignores every wake source
  wire [3:0] q = irq_s2 & ien[3:0] & {4{~imask_bit & ~lock}}; // R2
  wire dt_ok = direct_transfer_enable & ien[`PMC_IE_DT] & ~imask_bit; // R8
  wire is_sub = (mode == ST_SUB);

  wire setup = psel_in & penable_in & ~pready_out;
  wire acc = psel_in & penable_in & pready_out;
  wire wr = acc & pwrite_in;
  wire rd_stat = acc & ~pwrite_in & (paddr_in == `PMC_OFS_ISTAT);

  // ********************************
  // input synchronisers
  // ********************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      rpin_sync <= 2'h0;
      irq_s1 <= 4'h0;
      irq_s2 <= 4'h0;
    end else begin
      rpin_sync <= {rpin_sync[0], reset_pin_n_in};
      irq_s1 <= {other_irq_in, timer_a_irq_in,
                 ext_interrupt_one_in, ext_interrupt_zero_in};
      irq_s2 <= irq_s1;
    end
  end

  // ********************************
  // mode sequencer
  // ********************************
  always @* begin
    next_mode = mode;
    next_tgt = tgt;
    next_pend = pend;
    next_lock = lock;
    next_cnt = cnt;
    ev_dt = 1'b0;
    ev_wake = 1'b0;
    case (mode)
      ST_RST: begin
        if (rpin) begin
          next_mode = ST_AHS;
        end
      end
      ST_AHS, ST_AMS, ST_SUB: begin
        if (sleep_exec_in) begin
          if (direct_transfer_enable & imask_bit) begin
            next_lock = 1'b1; // R10
          end
          if (standby_enable & watch_timer_select) begin
            next_mode = ST_WAT; // R4
            if (dt_ok & low_speed_select & ~is_sub) begin
              next_tgt = ST_SUB; // R13
              next_pend = 1'b1;
            end else if (dt_ok & ~low_speed_select & is_sub) begin
              next_tgt = act_tgt; // R14
              next_pend = 1'b1;
            end
          end else if (standby_enable & ~low_speed_select & ~is_sub) begin
            next_mode = ST_STB; // R3
          end else if (~standby_enable & ~low_speed_select & ~is_sub) begin
            next_mode = medium_speed_select ? ST_SMS : ST_SHS; // R5
            if (dt_ok & (mode == ST_AHS) & medium_speed_select) begin // R9
              next_tgt = ST_AMS; // R11
              next_pend = 1'b1;
            end else if (dt_ok & (mode == ST_AMS) & ~medium_speed_select) begin
              next_tgt = ST_AHS; // R12
              next_pend = 1'b1;
            end
          end else if (~standby_enable & low_speed_select & watch_timer_select & is_sub) begin
            next_mode = ST_SSL;
          end
        end
      end
      ST_SHS, ST_SMS: begin
        if (pend) begin
          next_mode = tgt; // R8
          next_pend = 1'b0;
          ev_dt = 1'b1;
        end else if (|q) begin
          next_mode = (mode == ST_SMS) ? ST_AMS : ST_AHS; // R1
          ev_wake = 1'b1;
        end
      end
      ST_STB: begin
        if (q[`PMC_IE_EXT_INTERRUPT_ZERO] | q[`PMC_IE_EXT_INTERRUPT_ONE]) begin
          next_mode = ST_SET; // R1
          next_tgt = act_tgt;
          next_cnt = settle_cycles(sts);
        end
      end
      ST_WAT: begin
        if (pend) begin
          if (tgt == ST_SUB) begin
            next_mode = ST_SUB; // R13
            next_pend = 1'b0;
            ev_dt = 1'b1;
          end else begin
            next_mode = ST_SET; // R14
            next_cnt = settle_cycles(sts);
          end
        end else if (q[`PMC_IE_EXT_INTERRUPT_ZERO] | q[`PMC_IE_TMRA]) begin
          if (low_speed_select) begin
            next_mode = ST_SUB;
            ev_wake = 1'b1;
          end else begin
            next_mode = ST_SET; // R1
            next_tgt = act_tgt;
            next_cnt = settle_cycles(sts);
          end
        end
      end
      ST_SSL: begin
        if (|q) begin
          next_mode = ST_SUB;
          ev_wake = 1'b1;
        end
      end
      ST_SET: begin
        if (cnt == `PMC_CNT_ONE) begin
          next_mode = tgt; // R14
          next_pend = 1'b0;
          ev_dt = pend;
          ev_wake = ~pend;
          next_cnt = `PMC_CNT_ZERO;
        end else begin
          next_cnt = cnt - `PMC_CNT_ONE;
        end
      end
      default: begin
        next_mode = ST_RST;
      end
    endcase
    if (~rpin) begin
      next_mode = ST_RST; // R6
      next_pend = 1'b0;
      next_lock = 1'b0;
      next_cnt = `PMC_CNT_ZERO;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      mode <= ST_RST;
      tgt <= ST_AHS;
      pend <= 1'b0;
      lock <= 1'b0;
      cnt <= `PMC_CNT_ZERO;
    end else begin
      mode <= next_mode; // R16
      tgt <= next_tgt;
      pend <= next_pend;
      lock <= next_lock;
      cnt <= next_cnt;
    end
  end

  // ********************************
  // cpu clock enable
  // ********************************
  // divider restarts on every mode change so the first
  // enable after a switch comes one cycle after the switch
  always @(posedge clk_in) begin
    if (rst_in || (next_mode != mode)) begin
      dcnt <= `PMC_DIV_ZERO;
      cpu_clk_en_out <= 1'b0;
    end else begin
      case (mode)
        ST_AHS: begin
          dcnt <= `PMC_DIV_ZERO;
          cpu_clk_en_out <= 1'b1;
        end
        ST_AMS: begin
          cpu_clk_en_out <= (dcnt == `PMC_DIV_ZERO); // R7
          if (dcnt == `PMC_DIV_ZERO) begin
            dcnt <= (`PMC_MS_DIV_BASE << mdiv) - `PMC_DIV_ONE; // R7
          end else begin
            dcnt <= dcnt - `PMC_DIV_ONE;
          end
        end
        ST_SUB: begin
          cpu_clk_en_out <= (dcnt == `PMC_DIV_ZERO);
          if (dcnt == `PMC_DIV_ZERO) begin
            dcnt <= `PMC_SUB_DIV_M1;
          end else begin
            dcnt <= dcnt - `PMC_DIV_ONE;
          end
        end
        default: begin
          dcnt <= `PMC_DIV_ZERO;
          cpu_clk_en_out <= 1'b0;
        end
      endcase
    end
  end

  // ********************************
  // mode outputs
  // ********************************
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_out <= ST_RST;
      cpu_reset_out <= 1'b1;
      dt_exc_out <= 1'b0;
      wake_exc_out <= 1'b0;
    end else begin
      mode_out <= next_mode;
      cpu_reset_out <= (next_mode == ST_RST); // R6
      dt_exc_out <= ev_dt; // R8
      wake_exc_out <= ev_wake;
    end
  end

  // ********************************
  // apb registers
  // ********************************
  always @* begin
    next_err = 1'b0;
    next_rdata = 32'h00000000;
    case (paddr_in)
      `PMC_OFS_CTRL1: next_rdata[7:0] = ctrl1;
      `PMC_OFS_CTRL2: next_rdata[7:0] = ctrl2;
      `PMC_OFS_TMRA: next_rdata[7:0] = tmra;
      `PMC_OFS_CCR: next_rdata[7:0] = condition_code_reg;
      `PMC_OFS_IEN: next_rdata[4:0] = ien;
      `PMC_OFS_MODE: next_rdata[11:0] = {lock, pend, mode};
      `PMC_OFS_ISTAT: next_rdata[2:0] = istat;
      `PMC_OFS_IMASK: next_rdata[2:0] = imask;
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup & next_err;
      prdata_out <= (setup & ~pwrite_in) ? next_rdata : 32'h00000000;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      ctrl1 <= `PMC_RST_BYTE;
      ctrl2 <= `PMC_RST_BYTE;
      tmra <= `PMC_RST_BYTE;
      condition_code_reg <= `PMC_RST_CCR;
      ien <= `PMC_RST_IEN;
      imask <= `PMC_RST_EV;
    end else if (wr) begin
      case (paddr_in)
        `PMC_OFS_CTRL1: ctrl1 <= apb_byte(pwdata_in) & `PMC_C1_MASK;
        `PMC_OFS_CTRL2: ctrl2 <= apb_byte(pwdata_in) & `PMC_C2_MASK;
        `PMC_OFS_TMRA: tmra <= apb_byte(pwdata_in);
        `PMC_OFS_CCR: condition_code_reg <= apb_byte(pwdata_in);
        `PMC_OFS_IEN: ien <= pwdata_in[4:0];
        `PMC_OFS_IMASK: imask <= pwdata_in[2:0];
        default: ctrl1 <= ctrl1;
      endcase
    end
  end

  // ********************************
  // events and interrupt
  // ********************************
  // a new event in the clearing read's cycle survives
  wire [2:0] ev_now = {ev_wake, ev_dt, next_mode != mode};

  always @(posedge clk_in) begin
    if (rst_in) begin
      istat <= `PMC_RST_EV;
      irq_out <= 1'b0;
    end else begin
      istat <= (istat & {3{~rd_stat}}) | ev_now;
      irq_out <= |(((istat & {3{~rd_stat}}) | ev_now) & imask);
    end
  end

endmodule

// >>> sim/pmc_props.sv
// Purpose: port-level checks of the power mode controller
// Assumes: bound to pmc_top, one clock domain
// Notes: mode bits follow the one-hot map of mode_out
`timescale 1ns/1ps
module pmc_props (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // observed inputs
  input wire psel_in,
  input wire penable_in,
  input wire sleep_exec_in,
  input wire reset_pin_n_in,
  // observed outputs
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire [9:0] mode_out,
  input wire cpu_reset_out,
  input wire cpu_clk_en_out,
  input wire dt_exc_out
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    !pready_out ##1 pready_out;
  endsequence
  sequence s_ms_tick;
    mode_out[2] && cpu_clk_en_out ##1 mode_out[2];
  endsequence
  chk_apb_wait: assert property (s_setup |=> s_answer)
    else $error("apb answer not after one wait");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr_out |->
    pready_out && prdata_out == 32'h0)
    else $error("error response malformed");
  chk_idle_data: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  chk_one_mode: assert property ($onehot(mode_out))
    else $error("mode not one-hot");
  chk_reset_flag: assert property (cpu_reset_out == mode_out[0])
    else $error("cpu reset flag differs from mode");
  chk_pin_reset: assert property (!reset_pin_n_in |->
    ##[1:3] mode_out[0])
    else $error("reset pin did not force reset");
  chk_leave_hs: assert property ($past(mode_out[1]) && !mode_out[1] |->
    $past(sleep_exec_in) || mode_out[0])
    else $error("left high speed without cause");
  chk_dt_source: assert property (dt_exc_out |->
    $past(mode_out[4] | mode_out[5] | mode_out[7] | mode_out[9]) &&
    (mode_out[1] | mode_out[2] | mode_out[3]))
    else $error("direct transfer exception out of place");
  chk_ms_gap: assert property (s_ms_tick |-> !cpu_clk_en_out)
    else $error("medium speed clock too fast");
endmodule

bind pmc_top pmc_props pmc_props_i (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .sleep_exec_in(sleep_exec_in),
  .reset_pin_n_in(reset_pin_n_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .mode_out(mode_out), .cpu_reset_out(cpu_reset_out),
  .cpu_clk_en_out(cpu_clk_en_out), .dt_exc_out(dt_exc_out)
);

// >>> sim/tb.sv
// Purpose: self-checking bench of the power mode controller
// Assumes: settle_base shortened to 4 settle states
// Notes: the apb master waits for pready, never for a fixed count
`timescale 1ns/1ps
`include "pmc_consts.vh"
module tb;
  // ****
  // signals
  // ****
  logic clk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, rerr;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, rd, r;
  logic slp = 0, pin_n = 1, ext_interrupt_zero = 0, ext_interrupt_one = 0, timer_a_mode_reg = 0, oth = 0;
  wire [31:0] prd;
  wire [9:0] mode;
  wire rdy, err, crst, cen, dte, wke, irq;
  int miscompares = 0, n_compared = 0, n;
  // write flag, error flag, address, write data, expected read
  logic [31:0] rows [11] = '{32'h00000000, 32'h00080000, 32'h000c0080,
    32'h00100000, 32'h00140002, 32'h1000ff00, 32'h000000fb, 32'h1004ff00,
    32'h0004000c, 32'h11200500, 32'h01200000};
  pmc_top #(.settle_base(18'h00004)) pmc_top_i (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(err), .sleep_exec_in(slp),
    .reset_pin_n_in(pin_n), .ext_interrupt_zero_in(ext_interrupt_zero),
    .ext_interrupt_one_in(ext_interrupt_one), .timer_a_irq_in(timer_a_mode_reg),
    .other_irq_in(oth), .mode_out(mode), .cpu_reset_out(crst),
    .cpu_clk_en_out(cen), .dt_exc_out(dte), .wake_exc_out(wke),
    .irq_out(irq));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // ****
  // tasks
  // ****
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cmpb(input string nm, input logic e, input logic g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask
  task cmpm(input logic [9:0] e);
    cmp("mode", {22'h0, e}, {22'h0, mode});
  endtask
  // holds the request until the edge that samples pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in) pen <= 1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    if (k >= 20) cmpb("pready", 1'b1, rdy);
    rd = prd;
    rerr = err;
    psel <= 0;
    pen <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task sl(input logic [9:0] e);
    @(posedge clk_in) slp <= 1;
    @(posedge clk_in) slp <= 0;
    #1 cmpm(e);
  endtask
  task wm(input logic [9:0] e, input int lim);
    n = 0;
    while (mode !== e && n < lim) @(posedge clk_in) #1 n++;
    cmpm(e);
  endtask
  task st(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task settle(input logic [31:0] e, input logic [9:0] t, input logic x);
    wm(10'h200, 12);
    n = 0;
    while (mode === 10'h200 && n < 200) @(posedge clk_in) #1 n++;
    cmp("settle", e, 32'(n));
    cmpm(t);
    cmpb("wake_exc", !x, wke);
    cmpb("dt_exc", x, dte);
  endtask
  task dt(input logic [9:0] via, input logic [9:0] t);
    sl(via);
    st(1);
    cmpm(t);
    cmpb("dt_exc", 1'b1, dte);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    st(2);
    cmpm(10'h001);
    cmpb("cpu_reset", 1'b1, crst);
    @(posedge clk_in) rst_in <= 0;
    wm(10'h002, 10);
    foreach (rows[i]) begin
      r = rows[i];
      apb(r[28], r[23:16], {24'h0, r[15:8]});
      if (!r[28]) cmp("reg", {24'h0, r[7:0]}, rd);
      cmpb("slverr", r[24], rerr);
    end
    wr(`PMC_OFS_CCR, 32'h0);
    wr(`PMC_OFS_IEN, 32'h1f);
    wr(`PMC_OFS_IMASK, 32'h0);
    wr(`PMC_OFS_CTRL1, 32'h0);
    wr(`PMC_OFS_CTRL2, 32'h04);
    sl(10'h020);
    @(posedge clk_in) oth <= 1;
    wm(10'h004, 8);
    @(posedge clk_in) oth <= 0;
    wr(`PMC_OFS_CTRL1, 32'h02);
    st(40);
    n = 0;
    repeat (320) @(posedge clk_in) #1 n += cen;
    cmp("pulses", 32'h0a, 32'(n));
    // both blocking conditions hold the standby before the wake is let in
    wr(`PMC_OFS_CTRL1, 32'h80);
    wr(`PMC_OFS_CCR, 32'h80);
    sl(10'h040);
    @(posedge clk_in) ext_interrupt_zero <= 1;
    st(10);
    cmpm(10'h040);
    wr(`PMC_OFS_IEN, 32'h1e);
    wr(`PMC_OFS_CCR, 32'h0);
    st(10);
    cmpm(10'h040);
    wr(`PMC_OFS_IEN, 32'h1f);
    settle(32'h4, 10'h004, 1'b0);
    @(posedge clk_in) ext_interrupt_zero <= 0;
    // the other short settling codes, each woken from standby
    for (int c = 1; c < 4; c++) begin
      wr(`PMC_OFS_CTRL1, 32'h80 | (c << 4));
      sl(10'h040);
      @(posedge clk_in) ext_interrupt_zero <= 1;
      settle(32'h4 << c, 10'h004, 1'b0);
      @(posedge clk_in) ext_interrupt_zero <= 0;
    end
    wr(`PMC_OFS_CTRL1, 32'hc0);
    wr(`PMC_OFS_TMRA, 32'h08);
    sl(10'h080);
    @(posedge clk_in) timer_a_mode_reg <= 1;
    settle(32'h40, 10'h004, 1'b0);
    @(posedge clk_in) timer_a_mode_reg <= 0;
    wr(`PMC_OFS_CTRL1, 32'h0);
    wr(`PMC_OFS_TMRA, 32'h0);
    wr(`PMC_OFS_CTRL2, 32'h08);
    dt(10'h010, 10'h002);
    wr(`PMC_OFS_CTRL2, 32'h0c);
    dt(10'h020, 10'h004);
    wr(`PMC_OFS_CTRL1, 32'h88);
    wr(`PMC_OFS_TMRA, 32'h08);
    wr(`PMC_OFS_CTRL2, 32'h08);
    sl(10'h080);
    wm(10'h008, 4);
    wr(`PMC_OFS_CTRL1, 32'h80);
    sl(10'h080);
    settle(32'h4, 10'h002, 1'b1);
    wr(`PMC_OFS_CTRL1, 32'h0);
    wr(`PMC_OFS_TMRA, 32'h0);
    wr(`PMC_OFS_IEN, 32'h0f);
    sl(10'h010);
    st(10);
    cmpm(10'h010);
    @(posedge clk_in) ext_interrupt_one <= 1;
    wm(10'h002, 8);
    @(posedge clk_in) ext_interrupt_one <= 0;
    wr(`PMC_OFS_IEN, 32'h1f);
    wr(`PMC_OFS_CCR, 32'h80);
    sl(10'h010);
    wr(`PMC_OFS_CCR, 32'h0);
    @(posedge clk_in) ext_interrupt_zero <= 1;
    st(10);
    cmpm(10'h010);
    @(posedge clk_in) pin_n <= 0;
    st(3);
    cmpm(10'h001);
    @(posedge clk_in) pin_n <= 1;
    ext_interrupt_zero <= 0;
    wm(10'h002, 10);
    // events are masked while the status is cleared and refilled
    wr(`PMC_OFS_CTRL2, 32'h0);
    apb(1'b0, `PMC_OFS_ISTAT, 32'h0);
    sl(10'h010);
    st(2);
    cmpb("irq", 1'b0, irq);
    wr(`PMC_OFS_IMASK, 32'h01);
    st(2);
    cmpb("irq", 1'b1, irq);
    apb(1'b0, `PMC_OFS_ISTAT, 32'h0);
    cmp("istat", 32'h1, rd);
    st(2);
    cmpb("irq", 1'b0, irq);
    report_and_stop;
  end
  initial begin
    #50000;
    miscompares++;
    report_and_stop;
  end
endmodule
